/* pmsd_map.svh */
// register offsets, field layout, reset values, limits and timing counts
`ifndef PMSD_MAP_SVH
`define PMSD_MAP_SVH
`define PMSD_LIMIT_OFFSET 8'hc2
`define PMSD_LIMIT_LSB 0
`define PMSD_LIMIT_W 3
`define PMSD_LIMIT_RESET 3'h5
`define PMSD_CODE_NONE 3'h0
`define PMSD_CODE_1K 3'h1
`define PMSD_CODE_2K 3'h2
`define PMSD_CODE_4K 3'h3
`define PMSD_CODE_8K 3'h4
`define PMSD_CODE_16K 3'h5
`define PMSD_MAX_1K 16'h03ff
`define PMSD_MAX_2K 16'h07ff
`define PMSD_MAX_4K 16'h0fff
`define PMSD_MAX_8K 16'h1fff
`define PMSD_MAX_16K 16'h3fff
`define PMSD_ADDR_CYCLES 2
`define PMSD_STROBE_CYCLES 4
`endif

/* pmsd_pkg.sv */
// types shared by the program memory size decoder
package pmsd_pkg;
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_INT,
		ST_ADDR,
		ST_STROBE
	} pmsd_state_type;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} pmsd_sfr_req_type;

	typedef struct packed {
		pmsd_state_type state;
		logic [2:0] limit;
		logic [3:0] cnt;
		logic force_meta;
		logic force_sync;
		logic [7:0] din_meta;
		logic [7:0] din_sync;
		logic ready;
		logic rom_en;
		logic [13:0] rom_addr;
		logic fetch_valid;
		logic [7:0] fetch_data;
		logic fetch_ext;
		logic [7:0] rdata;
		logic [7:0] low_out;
		logic low_oe;
		logic [7:0] high_out;
		logic high_oe;
		logic latch;
		logic strobe_n;
		logic bus_active;
	} pmsd_regs_type;
endpackage

/* pmsd_decoder.sv */
// program fetch decoder: on-chip rom limit register and external program bus
`timescale 1ns/10ps
`default_nettype none
`include "pmsd_map.svh"

module pmsd_decoder #(
	parameter int unsigned ADDR_CYCLES = `PMSD_ADDR_CYCLES,
	parameter int unsigned STROBE_CYCLES = `PMSD_STROBE_CYCLES
) (
	// clock and reset
	input wire logic CLK,
	input wire logic RESETN,
	// special function register access from the core
	input wire pmsd_pkg::pmsd_sfr_req_type SFR_REQ,
	input wire logic TIMED_UNLOCK_KEY,
	output logic [7:0] SFR_RDATA,
	// program fetch request and answer
	input wire logic FETCH_REQ,
	input wire logic [15:0] FETCH_ADDR,
	output logic FETCH_READY,
	output logic FETCH_VALID,
	output logic [7:0] FETCH_DATA,
	output logic FETCH_EXTERNAL,
	// on-chip rom
	output logic ROM_EN,
	output logic [13:0] ROM_ADDR,
	input wire logic [7:0] ROM_DATA,
	// port latches used while the bus is idle
	input wire logic [7:0] GPIO_LOW_OUT,
	input wire logic GPIO_LOW_OE,
	input wire logic [7:0] GPIO_HIGH_OUT,
	input wire logic GPIO_HIGH_OE,
	// external pins
	input wire logic EXTERNAL_FETCH_FORCE_N,
	input wire logic [7:0] LOW_ADDRESS_DATA_PORT_IN,
	output logic [7:0] LOW_ADDRESS_DATA_PORT_OUT,
	output logic LOW_ADDRESS_DATA_PORT_OE,
	output logic [7:0] HIGH_ADDRESS_PORT_OUT,
	output logic HIGH_ADDRESS_PORT_OE,
	output logic ADDRESS_LATCH,
	output logic PROGRAM_STROBE_N,
	output logic BUS_ACTIVE
);
	pmsd_pkg::pmsd_regs_type r_reg;
	pmsd_pkg::pmsd_regs_type r_next;
	logic limit_hit;
	logic limit_write;
	logic [2:0] limit_new;
	logic on_chip;

	function automatic logic in_limit(input logic [2:0] code, input logic [15:0] a);
		logic hit;
		hit = 1'b0;
		unique case (code)
			`PMSD_CODE_NONE: hit = 1'b0;
			`PMSD_CODE_1K: hit = (a <= `PMSD_MAX_1K);
			`PMSD_CODE_2K: hit = (a <= `PMSD_MAX_2K);
			`PMSD_CODE_4K: hit = (a <= `PMSD_MAX_4K);
			`PMSD_CODE_8K: hit = (a <= `PMSD_MAX_8K);
			`PMSD_CODE_16K: hit = (a <= `PMSD_MAX_16K);
			default: hit = 1'b0;
		endcase
		return hit;
	endfunction

	always_comb begin
		r_next = r_reg;
		limit_hit = (SFR_REQ.addr == `PMSD_LIMIT_OFFSET);
		limit_new = SFR_REQ.wdata[`PMSD_LIMIT_LSB +: `PMSD_LIMIT_W];
		// reserved codes are refused and leave the field as it was
		limit_write = SFR_REQ.wr && limit_hit && TIMED_UNLOCK_KEY
			&& (limit_new <= `PMSD_CODE_16K);
		if (limit_write) begin
			r_next.limit = limit_new;
		end
		if (SFR_REQ.rd) begin
			r_next.rdata = limit_hit ? {5'h00, r_reg.limit} : 8'h00;
		end
		r_next.force_meta = EXTERNAL_FETCH_FORCE_N;
		r_next.force_sync = r_reg.force_meta;
		r_next.din_meta = LOW_ADDRESS_DATA_PORT_IN;
		r_next.din_sync = r_reg.din_meta;
		// decode against the limit as it stands after this edge
		on_chip = r_reg.force_sync && in_limit(r_next.limit, FETCH_ADDR);
		r_next.fetch_valid = 1'b0;
		r_next.rom_en = 1'b0;
		unique case (r_reg.state)
			pmsd_pkg::ST_IDLE: begin
				if (FETCH_REQ) begin
					r_next.cnt = 4'h0;
					r_next.fetch_ext = !on_chip;
					if (on_chip) begin
						r_next.state = pmsd_pkg::ST_INT;
						r_next.rom_en = 1'b1;
						r_next.rom_addr = FETCH_ADDR[13:0];
					end else begin
						r_next.state = pmsd_pkg::ST_ADDR;
						r_next.high_out = FETCH_ADDR[15:8];
						r_next.low_out = FETCH_ADDR[7:0];
					end
				end
			end
			pmsd_pkg::ST_INT: begin
				r_next.state = pmsd_pkg::ST_IDLE;
				r_next.fetch_valid = 1'b1;
				r_next.fetch_data = ROM_DATA;
			end
			pmsd_pkg::ST_ADDR: begin
				if (r_reg.cnt == 4'(ADDR_CYCLES - 1)) begin
					r_next.state = pmsd_pkg::ST_STROBE;
					r_next.cnt = 4'h0;
				end else begin
					r_next.cnt = r_reg.cnt + 4'h1;
				end
			end
			pmsd_pkg::ST_STROBE: begin
				if (r_reg.cnt == 4'(STROBE_CYCLES - 1)) begin
					r_next.state = pmsd_pkg::ST_IDLE;
					r_next.fetch_valid = 1'b1;
					r_next.fetch_data = r_reg.din_sync;
				end else begin
					r_next.cnt = r_reg.cnt + 4'h1;
				end
			end
		endcase
		r_next.ready = (r_next.state == pmsd_pkg::ST_IDLE);
		r_next.bus_active = (r_next.state == pmsd_pkg::ST_ADDR)
			|| (r_next.state == pmsd_pkg::ST_STROBE);
		r_next.latch = (r_next.state == pmsd_pkg::ST_ADDR);
		r_next.strobe_n = (r_next.state != pmsd_pkg::ST_STROBE);
		// bus owns the high port while active and the low port in the address phase only, port latches otherwise
		if (r_next.bus_active) begin
			r_next.high_oe = 1'b1;
			r_next.low_oe = (r_next.state == pmsd_pkg::ST_ADDR);
			if (r_reg.state == pmsd_pkg::ST_IDLE) begin
				r_next.high_out = FETCH_ADDR[15:8];
				r_next.low_out = FETCH_ADDR[7:0];
			end
		end else begin
			r_next.low_out = GPIO_LOW_OUT;
			r_next.low_oe = GPIO_LOW_OE;
			r_next.high_out = GPIO_HIGH_OUT;
			r_next.high_oe = GPIO_HIGH_OE;
		end
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			r_reg <= '0;
			r_reg.state <= pmsd_pkg::ST_IDLE;
			r_reg.limit <= `PMSD_LIMIT_RESET;
			r_reg.force_meta <= 1'b1;
			r_reg.force_sync <= 1'b1;
			r_reg.ready <= 1'b1;
			r_reg.strobe_n <= 1'b1;
		end else begin
			r_reg <= r_next;
		end
	end

	assign SFR_RDATA = r_reg.rdata;
	assign FETCH_READY = r_reg.ready;
	assign FETCH_VALID = r_reg.fetch_valid;
	assign FETCH_DATA = r_reg.fetch_data;
	assign FETCH_EXTERNAL = r_reg.fetch_ext;
	assign ROM_EN = r_reg.rom_en;
	assign ROM_ADDR = r_reg.rom_addr;
	assign LOW_ADDRESS_DATA_PORT_OUT = r_reg.low_out;
	assign LOW_ADDRESS_DATA_PORT_OE = r_reg.low_oe;
	assign HIGH_ADDRESS_PORT_OUT = r_reg.high_out;
	assign HIGH_ADDRESS_PORT_OE = r_reg.high_oe;
	assign ADDRESS_LATCH = r_reg.latch;
	assign PROGRAM_STROBE_N = r_reg.strobe_n;
	assign BUS_ACTIVE = r_reg.bus_active;

	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RESETN);

	a_locked_write_kept: assert property (
		(SFR_REQ.wr && !TIMED_UNLOCK_KEY) |=> (r_reg.limit == $past(r_reg.limit)))
		else $error("limit changed without timed unlock");

	a_unlocked_write_lands: assert property (
		(SFR_REQ.wr && TIMED_UNLOCK_KEY && SFR_REQ.addr == `PMSD_LIMIT_OFFSET
			&& SFR_REQ.wdata[2:0] <= 3'h5)
		|=> (r_reg.limit == $past(SFR_REQ.wdata[2:0])))
		else $error("unlocked limit write did not land");

	a_reserved_code_refused: assert property (
		(SFR_REQ.wr && SFR_REQ.wdata[2:0] > 3'h5) |=> (r_reg.limit == $past(r_reg.limit)))
		else $error("reserved limit code accepted");

	a_upper_bits_zero: assert property (
		$past(SFR_REQ.rd) |-> (SFR_RDATA[7:3] == 5'h00))
		else $error("upper limit bits read nonzero");

	a_force_pin_ext: assert property (
		(r_reg.state == pmsd_pkg::ST_IDLE && FETCH_REQ && !r_reg.force_sync)
		|=> (r_reg.state == pmsd_pkg::ST_ADDR) ##[1:12] (FETCH_VALID && FETCH_EXTERNAL))
		else $error("forced external fetch stayed internal");

	a_zero_size_ext: assert property (
		(r_reg.state == pmsd_pkg::ST_IDLE && FETCH_REQ && !SFR_REQ.wr
			&& r_reg.limit == 3'h0) |=> !ROM_EN && BUS_ACTIVE)
		else $error("fetch went on-chip with zero size");

	a_full_size_internal: assert property (
		(r_reg.state == pmsd_pkg::ST_IDLE && FETCH_REQ && !SFR_REQ.wr && r_reg.force_sync
			&& r_reg.limit == 3'h5 && FETCH_ADDR <= 16'h3fff)
		|=> ROM_EN ##1 (FETCH_VALID && !FETCH_EXTERNAL))
		else $error("in-range fetch did not use on-chip rom");

	a_above_limit_ext: assert property (
		(r_reg.state == pmsd_pkg::ST_IDLE && FETCH_REQ && !SFR_REQ.wr
			&& r_reg.limit == 3'h3 && FETCH_ADDR > 16'h0fff)
		|=> (HIGH_ADDRESS_PORT_OUT == $past(FETCH_ADDR[15:8]) && ADDRESS_LATCH
			&& LOW_ADDRESS_DATA_PORT_OUT == $past(FETCH_ADDR[7:0])))
		else $error("fetch above limit not placed on external bus");

	a_new_limit_next: assert property (
		(r_reg.state == pmsd_pkg::ST_IDLE && FETCH_REQ && SFR_REQ.wr && TIMED_UNLOCK_KEY
			&& SFR_REQ.addr == `PMSD_LIMIT_OFFSET && SFR_REQ.wdata[2:0] == 3'h0)
		|=> BUS_ACTIVE)
		else $error("new limit not applied to next fetch");

	a_strobe_width: assert property (
		$fell(PROGRAM_STROBE_N) |-> (!PROGRAM_STROBE_N && !LOW_ADDRESS_DATA_PORT_OE
			&& HIGH_ADDRESS_PORT_OE)[*4] ##1 (PROGRAM_STROBE_N && FETCH_VALID))
		else $error("program strobe low phase wrong");

	a_bus_owns_ports: assert property (
		ADDRESS_LATCH |-> (LOW_ADDRESS_DATA_PORT_OE && HIGH_ADDRESS_PORT_OE && BUS_ACTIVE))
		else $error("address phase without port ownership");

	a_limit_code_legal: assert property (
		r_reg.limit <= 3'h5)
		else $error("limit holds a reserved code");

	a_limit_only_unlocked: assert property (
		(r_reg.limit != $past(r_reg.limit)) |-> ($past(SFR_REQ.wr) && $past(TIMED_UNLOCK_KEY)))
		else $error("limit changed outside an unlocked write");

	a_rom_addr_match: assert property (
		ROM_EN |-> ({2'h0, ROM_ADDR} == $past(FETCH_ADDR)))
		else $error("rom address differs from fetch address");

	a_rom_one_cycle: assert property (
		ROM_EN |=> (FETCH_VALID && !FETCH_EXTERNAL
			&& FETCH_DATA == $past(ROM_DATA)))
		else $error("on-chip fetch data not returned next cycle");

	a_rom_no_bus: assert property (
		ROM_EN |-> (PROGRAM_STROBE_N && !BUS_ACTIVE && !FETCH_READY))
		else $error("on-chip fetch touched the external bus");

	a_strobe_is_ext: assert property (
		!PROGRAM_STROBE_N |-> (FETCH_EXTERNAL && BUS_ACTIVE && !ADDRESS_LATCH))
		else $error("program strobe low outside an external fetch");

	a_latch_to_strobe: assert property (
		$fell(ADDRESS_LATCH) |-> !PROGRAM_STROBE_N)
		else $error("strobe did not follow the address phase");

	a_addr_phase_len: assert property (
		$rose(ADDRESS_LATCH) |-> ADDRESS_LATCH[*2] ##1 !ADDRESS_LATCH)
		else $error("address phase length wrong");

	a_addr_held: assert property (
		(ADDRESS_LATCH && $past(ADDRESS_LATCH))
		|-> ($stable(HIGH_ADDRESS_PORT_OUT) && $stable(LOW_ADDRESS_DATA_PORT_OUT)))
		else $error("address moved during the address phase");

	a_high_port_owned: assert property (
		BUS_ACTIVE |-> HIGH_ADDRESS_PORT_OE)
		else $error("high port released during an external fetch");

	a_force_no_rom: assert property (
		!r_reg.force_sync |=> !ROM_EN)
		else $error("on-chip rom used while the force pin is low");

	a_zero_no_rom: assert property (
		(r_next.limit == 3'h0) |=> !ROM_EN)
		else $error("on-chip rom used with zero size");

	a_limit_read_back: assert property (
		($past(SFR_REQ.rd) && $past(SFR_REQ.addr) == `PMSD_LIMIT_OFFSET)
		|-> (SFR_RDATA == {5'h00, $past(r_reg.limit)}))
		else $error("limit read back wrong");
endmodule
`default_nettype wire

/* pmsd_ext_mem.sv */
// external program memory model on the multiplexed low port and the high port
`timescale 1ns/10ps
`default_nettype none
module pmsd_ext_mem (
	// clock and answer speed
	input wire logic clk,
	input wire logic slow,
	// bus from the decoder
	input wire logic [7:0] low_out,
	input wire logic low_oe,
	input wire logic [7:0] high_out,
	input wire logic latch,
	input wire logic strobe_n,
	// data back onto the low port
	output logic [7:0] pin
);
	logic [15:0] addr_q = 16'h0000;
	logic [7:0] last = 8'h00;
	logic busy = 1'b0;
	always_ff @(posedge clk) begin
		if (latch)
			addr_q <= {high_out, low_out};
		busy <= !strobe_n;
		last <= pin;
	end
	// data only while the strobe is low; a released bus shows the inverse of its last value
	assign pin = low_oe ? low_out : (!strobe_n && (!slow || busy)) ?
		(addr_q[7:0] ^ addr_q[15:8] ^ 8'h3c) : ~last;
endmodule
`default_nettype wire

/* test_program_memory_size_decoder.sv */
// self-checking testbench for the program memory size decoder
`timescale 1ns/10ps
`default_nettype none
module test_program_memory_size_decoder;
	localparam logic [15:0] TOP [6] = '{16'h0000, 16'h03ff, 16'h07ff, 16'h0fff, 16'h1fff, 16'h3fff};
	logic CLK = 1'b0;
	logic RESETN = 1'b0;
	pmsd_pkg::pmsd_sfr_req_type req = '0;
	logic key = 1'b0;
	logic freq = 1'b0;
	logic [15:0] faddr = 16'h0000;
	logic force_n = 1'b1;
	logic slow = 1'b0;
	logic [7:0] rdata, fdata, rom_data, pin, lo_out, hi_out;
	logic [13:0] rom_addr;
	logic ready, valid, fext, lo_oe, hi_oe, latch, strobe_n, rom_en, bus_act;
	int fail_count = 0;
	int compares = 0;
	assign rom_data = rom_addr[7:0] ^ {2'h0, rom_addr[13:8]} ^ 8'ha5;
	pmsd_decoder dut (.CLK(CLK), .RESETN(RESETN), .SFR_REQ(req), .TIMED_UNLOCK_KEY(key),
		.SFR_RDATA(rdata), .FETCH_REQ(freq), .FETCH_ADDR(faddr), .FETCH_READY(ready),
		.FETCH_VALID(valid), .FETCH_DATA(fdata), .FETCH_EXTERNAL(fext), .ROM_EN(rom_en),
		.ROM_ADDR(rom_addr), .ROM_DATA(rom_data), .GPIO_LOW_OUT(8'h6c), .GPIO_LOW_OE(1'b1),
		.GPIO_HIGH_OUT(8'h93), .GPIO_HIGH_OE(1'b1), .EXTERNAL_FETCH_FORCE_N(force_n),
		.LOW_ADDRESS_DATA_PORT_IN(pin), .LOW_ADDRESS_DATA_PORT_OUT(lo_out),
		.LOW_ADDRESS_DATA_PORT_OE(lo_oe), .HIGH_ADDRESS_PORT_OUT(hi_out),
		.HIGH_ADDRESS_PORT_OE(hi_oe), .ADDRESS_LATCH(latch), .PROGRAM_STROBE_N(strobe_n),
		.BUS_ACTIVE(bus_act));
	pmsd_ext_mem mem (.clk(CLK), .slow(slow), .low_out(lo_out), .low_oe(lo_oe),
		.high_out(hi_out), .latch(latch), .strobe_n(strobe_n), .pin(pin));
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic sfr(input logic wr, input logic [7:0] a, input logic [7:0] d, input logic k);
		req = '{wr: wr, rd: !wr, addr: a, wdata: d};
		key = k;
		@(negedge CLK);
		req = '0;
		key = 1'b0;
		@(negedge CLK);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		sfr(1'b0, a, 8'h00, 1'b0);
		chk({8'h00, rdata}, {8'h00, exp});
	endtask
	task automatic fetch(input logic [15:0] a, input logic ext);
		logic [7:0] exp;
		logic saw_lo;
		logic saw_hi;
		logic saw_rom;
		logic saw_bus;
		exp = ext ? (a[7:0] ^ a[15:8] ^ 8'h3c) : (a[7:0] ^ {2'h0, a[13:8]} ^ 8'ha5);
		saw_lo = 1'b0;
		saw_hi = 1'b0;
		saw_rom = 1'b0;
		saw_bus = 1'b0;
		freq = 1'b1;
		faddr = a;
		@(negedge CLK);
		freq = 1'b0;
		req = '0;
		key = 1'b0;
		for (int i = 0; i < 20 && valid !== 1'b1; i++) begin
			if (latch === 1'b1 && lo_oe === 1'b1 && hi_oe === 1'b1 && {hi_out, lo_out} === a)
				saw_hi = 1'b1;
			if (strobe_n === 1'b0)
				saw_lo = 1'b1;
			if (rom_en === 1'b1)
				saw_rom = 1'b1;
			if (bus_act === 1'b1)
				saw_bus = 1'b1;
			@(negedge CLK);
		end
		chk({13'h0000, saw_bus, saw_rom, ready}, {13'h0000, ext, !ext, 1'b1});
		chk({15'h0000, valid}, 16'h0001);
		chk({15'h0000, fext}, {15'h0000, ext});
		chk({8'h00, fdata}, {8'h00, exp});
		chk({14'h0000, saw_hi, saw_lo}, {14'h0000, ext, ext});
		chk({lo_out, hi_out}, 16'h6c93);
	endtask
	task automatic t_reset;
		rd_chk(8'hc2, 8'h05);
		fetch(16'h3fff, 1'b0);
		fetch(16'h4000, 1'b1);
		fetch(16'hffff, 1'b1);
		$display("test reset done");
	endtask
	task automatic t_codes;
		for (int c = 5; c >= 0; c--) begin
			sfr(1'b1, 8'hc2, 8'(c), 1'b1);
			fetch(TOP[c] + 16'h0001, 1'b1);
			if (c == 0)
				fetch(16'h0000, 1'b1);
			else
				fetch(TOP[c], 1'b0);
			rd_chk(8'hc2, 8'(c));
		end
		$display("test codes done");
	endtask
	task automatic t_lock;
		sfr(1'b1, 8'hc2, 8'h03, 1'b0);
		rd_chk(8'hc2, 8'h00);
		sfr(1'b1, 8'hc2, 8'h06, 1'b1);
		sfr(1'b1, 8'hc2, 8'h07, 1'b1);
		rd_chk(8'hc2, 8'h00);
		sfr(1'b1, 8'hc2, 8'hfa, 1'b1);
		rd_chk(8'hc2, 8'h02);
		sfr(1'b1, 8'hc3, 8'h05, 1'b1);
		rd_chk(8'hc2, 8'h02);
		rd_chk(8'hc3, 8'h00);
		$display("test lock done");
	endtask
	task automatic t_force;
		sfr(1'b1, 8'hc2, 8'h05, 1'b1);
		force_n = 1'b0;
		slow = 1'b1;
		repeat (3) @(negedge CLK);
		fetch(16'h0010, 1'b1);
		fetch(16'h3fff, 1'b1);
		force_n = 1'b1;
		slow = 1'b0;
		repeat (3) @(negedge CLK);
		fetch(16'h0010, 1'b0);
		$display("test force done");
	endtask
	task automatic t_switch;
		sfr(1'b1, 8'hc2, 8'h05, 1'b1);
		req = '{wr: 1'b1, rd: 1'b0, addr: 8'hc2, wdata: 8'h00};
		key = 1'b1;
		fetch(16'h0010, 1'b1);
		req = '{wr: 1'b1, rd: 1'b0, addr: 8'hc2, wdata: 8'h05};
		key = 1'b1;
		fetch(16'h0010, 1'b0);
		rd_chk(8'hc2, 8'h05);
		$display("test switch done");
	endtask
	task automatic t_rereset;
		sfr(1'b1, 8'hc2, 8'h01, 1'b1);
		RESETN = 1'b0;
		repeat (2) @(negedge CLK);
		RESETN = 1'b1;
		repeat (2) @(negedge CLK);
		rd_chk(8'hc2, 8'h05);
		fetch(16'h3fff, 1'b0);
		$display("test rereset done");
	endtask
	task automatic close_out;
		$display("comparisons %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		forever #5 CLK = ~CLK;
	end
	initial begin
		repeat (12) @(negedge CLK);
		RESETN = 1'b1;
		repeat (2) @(negedge CLK);
		t_reset;
		t_codes;
		t_lock;
		t_force;
		t_switch;
		t_rereset;
		close_out;
	end
	initial begin
		#50000;
		fail_count++;
		close_out;
	end
endmodule
`default_nettype wire
